// file: rtl/ictc_defines.svh
// Constants for the input capture trigger control block.
`ifndef ICTC_DEFINES_SVH
`define ICTC_DEFINES_SVH
`define ICTC_ADDR_W          4
`define ICTC_ADDR_CTRL2      4'h0
`define ICTC_ADDR_TIMER_LO   4'h1
`define ICTC_ADDR_TIMER_HI   4'h2
`define ICTC_BIT_CASCADE     8
`define ICTC_BIT_TRIG_MODE   7
`define ICTC_BIT_TRIG_STAT   6
`define ICTC_SYNC_HI         4
`define ICTC_SYNC_LO         0
`define ICTC_SYNC_RESET      5'h0D
`define ICTC_SYNC_PTG        5'h0A
`define ICTC_SYNC_SELF       5'h00
`define ICTC_CTRL_WMASK      16'h01DF
`define ICTC_TIMER_ZERO      16'h0000
`define ICTC_DATA_ZERO       32'h00000000
`define ICTC_NUM_SRC         32
`endif

// file: rtl/ictc_pkg.sv
// Types shared by the input capture trigger control block.
package ictc_pkg;
    typedef struct packed {
        logic       cascade_pair_select;
        logic       trigger_mode_select;
        logic [4:0] sync_source_select;
    } ictc_ctrl_s;
    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } ictc_avm_req_s;
    typedef enum logic [1:0] {ICTC_IDLE, ICTC_ANSWER} ictc_bus_e;
endpackage

// file: rtl/ictc_sync2.sv
// Two flip-flop synchroniser for one level from outside the clock domain.
module ictc_sync2 (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic d,
    output logic      q
);
    logic meta_reg;

    // The first stage feeds only the second.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= 1'b0;
            q        <= 1'b0;
        end else if (ce) begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

// file: rtl/ictc_timer.sv
// Sixteen-bit channel timer half with clear, hold and carry out.
module ictc_timer (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        clear,
    input  wire logic        count_en,
    output logic [15:0]      value,
    output logic             carry
);
    // Carry is combinational so the upper half steps in the same cycle.
    assign carry = count_en && (value == 16'hFFFF);

    // Clear wins over counting; the timer holds when not enabled.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            value <= 16'h0000;
        end else if (ce) begin
            if (clear) begin
                value <= 16'h0000;
            end else if (count_en) begin
                value <= value + 16'h0001;
            end
        end
    end
endmodule

// file: rtl/ictc_top.sv
// Control register two of a capture channel with trigger, sync and cascade logic.
`include "ictc_defines.svh"

module ictc_top (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  ce,
    input  wire logic [3:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest,
    input  wire logic [31:0]           sync_sources,
    input  wire logic                  generator_trigger,
    input  wire logic                  pair_cascade_select,
    output logic [31:0]                channel_timer,
    output logic                       timer_trigger_status,
    output ictc_pkg::ictc_ctrl_s       ctrl_out
);
    import ictc_pkg::*;

    ictc_ctrl_s         ctrl_reg;
    logic               trig_stat_reg;
    ictc_bus_e          bus_state_reg;
    logic [31:0]        readdata_reg;
    logic [31:0]        src_sync;
    logic [31:0]        src_prev_reg;
    logic [31:0]        src_rise;
    logic               gen_sync;
    logic               sel_event;
    logic               accept;
    logic               wr_ctrl;
    logic               sw_set;
    logic               sw_clear;
    logic [15:0]        ctrl_view;
    logic [15:0]        lo_value;
    logic [15:0]        hi_value;
    logic               lo_carry;
    logic               cascade_on;
    logic               timer_clear;
    logic               lo_count;
    logic               hi_count;

    // Every external source crosses two flip-flops before use.
    genvar g;
    generate
        for (g = 0; g < `ICTC_NUM_SRC; g++) begin : g_src
            ictc_sync2 u_sync (
                .clk (clk),
                .rst (rst),
                .ce  (ce),
                .d   (sync_sources[g]),
                .q   (src_sync[g])
            );
        end
    endgenerate

    // The dedicated generator output has its own synchroniser.
    ictc_sync2 u_gen_sync (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .d   (generator_trigger),
        .q   (gen_sync)
    );

    // Edge memory looks only at synchronised levels.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src_prev_reg <= `ICTC_DATA_ZERO;
        end else if (ce) begin
            src_prev_reg <= src_sync;
        end
    end

    // The generator input replaces one slot so each channel has exactly one.
    always_comb begin
        src_rise = src_sync & ~src_prev_reg;
        src_rise[`ICTC_SYNC_PTG] = gen_sync & ~src_prev_reg[`ICTC_SYNC_PTG];
    end

    // Code zero stands for the channel itself and never fires.
    assign sel_event = (ctrl_reg.sync_source_select != `ICTC_SYNC_SELF)
                       && src_rise[ctrl_reg.sync_source_select];

    // The bus answers in the cycle after the request is seen.
    assign accept          = (bus_state_reg == ICTC_ANSWER);
    assign avs_waitrequest = (avs_read || avs_write) && !accept;
    assign avs_readdata    = readdata_reg;

    // Waitrequest drops one cycle after the request; the state returns to idle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_state_reg <= ICTC_IDLE;
        end else if (ce) begin
            case (bus_state_reg)
                ICTC_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_state_reg <= ICTC_ANSWER;
                    end
                end
                default: begin
                    bus_state_reg <= ICTC_IDLE;
                end
            endcase
        end
    end

    assign wr_ctrl = accept && avs_write && (avs_address == `ICTC_ADDR_CTRL2);

    // Control fields; a missing low byte lane keeps the low fields.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg.cascade_pair_select <= 1'b0;
            ctrl_reg.trigger_mode_select <= 1'b0;
            ctrl_reg.sync_source_select  <= `ICTC_SYNC_RESET;
        end else if (ce && wr_ctrl) begin
            if (avs_byteenable[1]) begin
                ctrl_reg.cascade_pair_select <= avs_writedata[`ICTC_BIT_CASCADE];
            end
            if (avs_byteenable[0]) begin
                ctrl_reg.trigger_mode_select <= avs_writedata[`ICTC_BIT_TRIG_MODE];
                ctrl_reg.sync_source_select  <=
                    avs_writedata[`ICTC_SYNC_HI:`ICTC_SYNC_LO];
            end
        end
    end

    assign sw_set   = wr_ctrl && avs_byteenable[0] && avs_writedata[`ICTC_BIT_TRIG_STAT];
    assign sw_clear = wr_ctrl && avs_byteenable[0] && !avs_writedata[`ICTC_BIT_TRIG_STAT];

    // Hardware set wins over a software clear in the same cycle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_stat_reg <= 1'b0;
        end else if (ce) begin
            if (sel_event || sw_set) begin
                trig_stat_reg <= 1'b1;
            end else if (sw_clear) begin
                trig_stat_reg <= 1'b0;
            end
        end
    end

    assign timer_trigger_status = trig_stat_reg;

    // Unimplemented bits are tied to zero in the read view.
    always_comb begin
        ctrl_view = `ICTC_TIMER_ZERO;
        ctrl_view[`ICTC_BIT_CASCADE]             = ctrl_reg.cascade_pair_select;
        ctrl_view[`ICTC_BIT_TRIG_MODE]           = ctrl_reg.trigger_mode_select;
        ctrl_view[`ICTC_BIT_TRIG_STAT]           = trig_stat_reg;
        ctrl_view[`ICTC_SYNC_HI:`ICTC_SYNC_LO]   = ctrl_reg.sync_source_select;
    end

    // Read data is registered when the request is seen and stands at the answer edge.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readdata_reg <= `ICTC_DATA_ZERO;
        end else if (ce && !accept && avs_read) begin
            if (avs_address == `ICTC_ADDR_CTRL2) begin
                readdata_reg <= {16'h0000, ctrl_view};
            end else if (avs_address == `ICTC_ADDR_TIMER_LO) begin
                readdata_reg <= {16'h0000, lo_value};
            end else if (avs_address == `ICTC_ADDR_TIMER_HI) begin
                readdata_reg <= {16'h0000, hi_value};
            end else begin
                readdata_reg <= `ICTC_DATA_ZERO;
            end
        end
    end

    // Cascade needs this channel's bit and its partner's bit.
    assign cascade_on = ctrl_reg.cascade_pair_select && pair_cascade_select;

    // Trigger mode: held clear until status is set, cleared again on status clear.
    // Sync mode: free running, restarted from zero by each source event.
    always_comb begin
        if (ctrl_reg.trigger_mode_select) begin
            timer_clear = !trig_stat_reg;
            lo_count    = trig_stat_reg;
        end else begin
            timer_clear = sel_event;
            lo_count    = 1'b1;
        end
    end

    // Upper half steps on carry only when cascaded, otherwise stays zero.
    assign hi_count = cascade_on && lo_carry;

    ictc_timer u_lo (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .clear    (timer_clear),
        .count_en (lo_count),
        .value    (lo_value),
        .carry    (lo_carry)
    );

    ictc_timer u_hi (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .clear    (timer_clear || !cascade_on),
        .count_en (hi_count),
        .value    (hi_value),
        .carry    ()
    );

    assign channel_timer = {hi_value, lo_value};
    assign ctrl_out      = ctrl_reg;
endmodule

// file: tb/ictc_checker.sv
// Concurrent checks on the ports of the capture trigger control block.
module ictc_checker (
    input wire logic             clk,
    input wire logic             rst,
    input wire logic [3:0]       avs_address,
    input wire logic             avs_read,
    input wire logic             avs_write,
    input wire logic [31:0]      avs_writedata,
    input wire logic [3:0]       avs_byteenable,
    input wire logic [31:0]      avs_readdata,
    input wire logic             avs_waitrequest,
    input wire logic             generator_trigger,
    input wire logic             pair_cascade_select,
    input wire logic [31:0]      channel_timer,
    input wire logic             timer_trigger_status,
    input wire ictc_pkg::ictc_ctrl_s ctrl_out
);
    import ictc_pkg::*;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // An accepted access to the control word.
    wire acc = !avs_waitrequest && (avs_address == 4'h0);
    wire tm = ctrl_out.trigger_mode_select;
    wire [4:0] sel = ctrl_out.sync_source_select;
    property p_unimpl;
        avs_read && acc |-> avs_readdata[31:9] == 23'h0 && !avs_readdata[5];
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("reserved bits not zero");
    property p_ctrl;
        avs_write && acc && avs_byteenable[0] |=>
            sel == $past(avs_writedata[4:0]) && tm == $past(avs_writedata[7]);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("source or mode not stored");
    property p_held;
        (!timer_trigger_status && tm) [*2] |-> channel_timer == 32'h0;
    endproperty
    a_held: assert property (p_held) else $error("untriggered timer not held");
    property p_count;
        (timer_trigger_status && tm) [*2] |->
            channel_timer[15:0] == $past(channel_timer[15:0]) + 16'h1;
    endproperty
    a_count: assert property (p_count) else $error("triggered timer not counting");
    property p_hi;
        !(ctrl_out.cascade_pair_select && pair_cascade_select) [*2] |->
            channel_timer[31:16] == 16'h0;
    endproperty
    a_hi: assert property (p_hi) else $error("upper half moved uncascaded");
    property p_trig;
        sel == 5'h0A && $rose(generator_trigger) |-> ##[1:4] timer_trigger_status;
    endproperty
    a_trig: assert property (p_trig) else $error("source event did not set status");
    property p_self;
        sel == 5'h00 && $past(sel, 4) == 5'h00 && !timer_trigger_status && !avs_write
            |=> !timer_trigger_status;
    endproperty
    a_self: assert property (p_self) else $error("self source set status");
    property p_clr;
        avs_write && acc && avs_byteenable[0] && !avs_writedata[6] && sel == 5'h00
            && avs_writedata[4:0] == 5'h00 |=> !timer_trigger_status;
    endproperty
    a_clr: assert property (p_clr) else $error("software clear ignored");
    c_trig: cover property (tm && $rose(timer_trigger_status));
    c_casc: cover property (channel_timer[31:16] != 16'h0);
    c_read: cover property (avs_read && acc);
endmodule

bind ictc_top ictc_checker u_chk (.clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .generator_trigger,
    .pair_cascade_select, .channel_timer, .timer_trigger_status, .ctrl_out);

// file: tb/ictc_far.sv
// Far side model: neighbour timers and the trigger generator driving the sources.
module ictc_far (
    input  wire logic       clk,
    input  wire logic       noise_en,
    input  wire logic       fire,
    input  wire logic       pair_in,
    input  wire logic [4:0] sel,
    output logic [31:0]     sync_sources,
    output logic            generator_trigger,
    output logic            pair_cascade_select
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] pulse_reg = 3'h0;
    logic       noise_reg = 1'b0;
    // A fire request gives a four-cycle pulse; unselected lines toggle so a bad mux shows.
    always_ff @(posedge clk) begin
        pulse_reg <= fire ? 3'h4 : ((pulse_reg != 3'h0) ? pulse_reg - 3'h1 : 3'h0);
        noise_reg <= noise_en && !noise_reg;
    end
    wire p = (pulse_reg != 3'h0);
    // The generator owns slot ten and feeds this one channel only.
    // It carries only the pulse, so a select change cannot expose stale noise as an edge.
    assign generator_trigger = p;
    assign sync_sources = ({32{noise_reg}} & ~(32'h1 << sel)) | (32'(p) << sel);
    // Software sets the neighbour's cascade bit as well before cascading.
    assign pair_cascade_select = pair_in;
endmodule

// file: tb/testbench.sv
// Self-checking bench for the capture trigger control block.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import ictc_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic        noise = 1'b0;
    logic        fire = 1'b0;
    logic        pin = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [3:0]  be = 4'h0;
    logic [31:0] wd = 32'h0;
    logic [31:0] q, t1, mdl, rdata, tmr, srcs;
    logic        wreq, stat, gen, pair;
    ictc_ctrl_s  ctrl;
    int          failures = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          ca, c0, i;
    int          x = 52;
    ictc_top dut (.clk(clk), .rst(rst), .ce(1'b1), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .sync_sources(srcs), .generator_trigger(gen),
        .pair_cascade_select(pair), .channel_timer(tmr), .timer_trigger_status(stat),
        .ctrl_out(ctrl));
    ictc_far far (.clk(clk), .noise_en(noise), .fire(fire), .pair_in(pin),
        .sel(ctrl.sync_source_select), .sync_sources(srcs), .generator_trigger(gen),
        .pair_cascade_select(pair));
    initial begin
        forever #10 clk = ~clk;
    end
    // The cascade test alone needs about 66000 cycles, so the ceiling sits well above.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            failures = failures + 1;
            summarize();
        end
    end
    function automatic logic [31:0] rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return 32'(x);
    endfunction
    // One bus cycle; the request is held until waitrequest is seen low at an edge.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        @(posedge clk);
        adr <= a;
        wd <= d;
        be <= b;
        rd <= !w;
        wr <= w;
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        q = rdata;
        ca = cyc;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // Write the control word and update the model: lane one holds only the cascade bit.
    task automatic wctl(input logic [31:0] d, input logic [3:0] b);
        bus(1'b1, 4'h0, d, b);
        if (b[0]) mdl = (mdl & 32'h100) | (d & 32'hDF);
        if (b[1]) mdl = (mdl & 32'hDF) | (d & 32'h100);
    endtask
    task automatic rdw(input logic [3:0] a);
        bus(1'b0, a, 32'h0, 4'h0);
    endtask
    task automatic pulse();
        int j;
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        for (j = 0; j < 20 && stat !== 1'b1; j++) @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Main sequence: reset map, random control words, trigger, sync, self, cascade.
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        mdl = 32'h0000000D;
        rdw(4'h0);
        chk(q, mdl);
        bus(1'b1, 4'h3, 32'hFFFFFFFF, 4'hF);
        rdw(4'h3);
        chk(q, 32'h0);
        $display("reset and map test done");
        wctl(32'h0, 4'hF);
        noise <= 1'b1;
        for (i = 0; i < 8; i++) begin
            wctl(rnd() & 32'hFFFFFFE0, 4'(rnd()));
            rdw(4'h0);
            chk(q, mdl);
        end
        $display("random control test done");
        // The generator slot is used as a trigger source first.
        wctl(32'h8A, 4'h1);
        rdw(4'h1);
        chk(q, 32'h0);
        pulse();
        chk(32'(stat), 32'h1);
        mdl[6] = 1'b1;
        rdw(4'h0);
        chk(q, mdl);
        rdw(4'h1);
        t1 = q;
        c0 = ca;
        rdw(4'h1);
        chk(q, t1 + 32'(ca - c0));
        wctl(32'h8A, 4'h1);
        rdw(4'h1);
        chk(q, 32'h0);
        $display("trigger mode test done");
        wctl(32'h0A, 4'h1);
        repeat (20) @(posedge clk);
        rdw(4'h1);
        t1 = q;
        pulse();
        mdl[6] = 1'b1;
        rdw(4'h1);
        chk(32'(q < t1), 32'h1);
        rdw(4'h0);
        chk(q, mdl);
        $display("sync mode test done");
        // This scenario names the channel itself, as do the random control and cascade tests; trigger and sync use slot ten.
        wctl(32'h80, 4'h1);
        pulse();
        rdw(4'h0);
        chk(q, mdl);
        $display("self source test done");
        pin <= 1'b1;
        wctl(32'h1C0, 4'h3);
        repeat (66000) @(posedge clk);
        rdw(4'h2);
        chk(q, 32'h1);
        $display("cascade test done");
        summarize();
    end
endmodule
